// File: rss_top.sv
// Ramp and reference switch status register with Wishbone access
// How it works
// RQ1: Bit 13 follows the live stall detector output.
// RQ2: Bit 12 sets when the ramp reverses; write one clears it.
// RQ3: Bit 11 shows the post-stop standstill wait is running.
// RQ4: Bit 10 reads one while present velocity is zero.
// RQ5: Bit 9 reads one while present and goal position match.
// RQ6: Bit 8 reads one while present and top velocity match.
// RQ7: Bit 7 sets on position reached rising; write one clears flag and interrupt.
// RQ8: Bit 6 sets on stall stop; write one clears flag and stall halt.
// RQ9: Bits 5 and 4 show switch stops; hold or opposite move removes them.
// RQ10: In soft stop a switch stop holds until motion toward it has ended.
// RQ11: Disabling a switch stop clears its flag and motion continues.
// RQ12: Interrupt is OR of bits 7 to 4.
// RQ13: Bits 3 and 2 set on position capture; write one clears them.
// RQ14: Bits 1 and 0 show live right and left switch active states.
// RQ15: A polarity bit picks high or low as the switch active level.
// RQ16: Enabled switch edges capture present position into the latch register.
// RQ17: Writing zero to clearable bits or writing read-only bits changes nothing.
//
// The implementer's own choices: register access over Wishbone and the register offsets.
module rss_top #(
	parameter int POS_W = 32,
	parameter int VEL_W = 32
) (
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	// Wishbone slave
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [7:0]              wb_adr_i,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic [31:0]             wb_dat_i,
	output logic                         wb_ack_o,
	output logic      [31:0]             wb_dat_o,
	// Motion generator and stall detector, same clock
	input  wire logic signed [VEL_W-1:0] presentVelocity,
	input  wire logic        [VEL_W-1:0] topVelocity,
	input  wire logic        [POS_W-1:0] presentPosition,
	input  wire logic        [POS_W-1:0] goalPosition,
	input  wire logic                    stallLiveIn,
	input  wire logic                    reverseEvent,
	input  wire logic                    zeroWaitActive,
	input  wire logic                    rampHold,
	input  wire logic                    moveCmd,
	input  wire logic                    moveCmdNegative,
	// Reference switch pins, asynchronous
	input  wire logic                    rightHomeInput,
	input  wire logic                    leftHomeInput,
	// Outputs
	output logic                         irq,
	output logic                         stallHaltOut,
	output logic                         stopRightOut,
	output logic                         stopLeftOut
);
	// ==========================================================
	// Reset release
	logic [1:0] rstSync_q;
	wire        rstN = rstSync_q[1];

	// Assert at once, release two edges later
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rstSync_q <= 2'b00;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end

	// ==========================================================
	// Helpers
	function automatic logic [31:0] laneMask(input logic [3:0] sel);
		laneMask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	// ==========================================================
	// Register state
	logic [13:0]      w1c_q;
	logic [11:0]      cfg_q;
	logic [13:0]      mask_q;
	logic [POS_W-1:0] captured_q;
	logic             stallLive_q;
	logic             zeroWait_q;
	logic             vzero_q;
	logic             posReached_q;
	logic             velReached_q;
	logic             ack_q;
	logic [31:0]      dat_q;
	logic             irq_q;
	logic             stallHalt_q;
	logic [1:0]       pinSync;
	logic [1:0]       swActive;
	logic [1:0]       swStop;
	logic [1:0]       latchReq;

	// ==========================================================
	// Bus decode
	wire        busReq   = wb_cyc_i & wb_stb_i;
	wire        busWrite = busReq & wb_we_i & ack_q;
	wire [31:0] wrLanes  = wb_dat_i & laneMask(wb_sel_i);
	wire [31:0] keepLanes = ~laneMask(wb_sel_i);
	wire        hitStatus = wb_adr_i == rss_pkg::OFS_STATUS;
	wire        hitConfig = wb_adr_i == rss_pkg::OFS_CONFIG;
	wire        hitMask   = wb_adr_i == rss_pkg::OFS_MASK;
	wire        hitLatch  = wb_adr_i == rss_pkg::OFS_LATCH;
	wire        wrStatus  = busWrite & hitStatus;
	wire        wrConfig  = busWrite & hitConfig;
	wire        wrMask    = busWrite & hitMask;

	// ==========================================================
	// Configuration fields
	wire       softStop   = cfg_q[rss_pkg::CF_SOFT_STOP];
	wire       stallHalt  = cfg_q[rss_pkg::CF_STALL_HALT];
	wire       velPos     = ~presentVelocity[VEL_W-1] & (presentVelocity != '0);
	wire       velNeg     = presentVelocity[VEL_W-1];
	wire [1:0] toward     = {velPos, velNeg};
	wire [1:0] opposite   = {moveCmd & moveCmdNegative, moveCmd & ~moveCmdNegative};

	// ==========================================================
	// Synchronise switch pins, index 0 left and 1 right
	rss_sync2 #(
		.W(2)
	) u_pinSync (
		.clk     (clk),
		.rstN    (rstN),
		.asyncIn ({rightHomeInput, leftHomeInput}),
		.syncOut (pinSync)
	);

	// One instance per switch; right stop and polarity bits sit one bit above left, right latch bits two above
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_side
			rss_switch_side u_side (
				.clk             (clk),
				.rstN            (rstN),
				.pinLevel        (pinSync[gi]),
				.polarity        (cfg_q[rss_pkg::CF_POL_L + gi]),
				.stopEnable      (cfg_q[rss_pkg::CF_STOP_L_EN + gi]),
				.latchOnActive   (cfg_q[rss_pkg::CF_LATCH_L_ACT + 2*gi]),
				.latchOnInactive (cfg_q[rss_pkg::CF_LATCH_L_INA + 2*gi]),
				.movingToward    (toward[gi]),
				.vzero           (vzero_q),
				.softStop        (softStop),
				.rampHold        (rampHold),
				.oppositeCmd     (opposite[gi]),
				.activeQ         (swActive[gi]),
				.stopFlagQ       (swStop[gi]),
				.latchReqQ       (latchReq[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Live conditions and sticky events
	wire posReachedD = presentPosition == goalPosition;     // RQ5
	wire velReachedD = presentVelocity == topVelocity;      // RQ6
	wire vzeroD      = presentVelocity == '0;               // RQ4
	wire [13:0] setVec = {1'b0, reverseEvent, 4'h0,         // RQ2
		posReachedD & ~posReached_q,                        // RQ7
		stallLive_q & stallHalt,                        // RQ8
		2'b00, latchReq[1], latchReq[0], 2'b00};            // RQ13
	// Only clearable bits react to writes of one
	wire [13:0] clrVec = wrStatus ? (wrLanes[13:0] & rss_pkg::W1C_BITS) : 14'h0000; // RQ17
	wire [13:0] w1cD   = (w1c_q & ~clrVec) | setVec;        // set wins over clear

	wire [13:0] statusWord = {stallLive_q, w1c_q[12], zeroWait_q, vzero_q,
		posReached_q, velReached_q, w1c_q[7], w1c_q[6], swStop[1], swStop[0],
		w1c_q[3], w1c_q[2], swActive[1], swActive[0]};      // RQ14
	wire irqD = |(statusWord & mask_q & rss_pkg::IRQ_BITS); // RQ12

	// Sample condition inputs
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			stallLive_q  <= 1'b0;
			zeroWait_q   <= 1'b0;
			vzero_q      <= 1'b0;
			posReached_q <= 1'b0;
			velReached_q <= 1'b0;
		end else begin
			stallLive_q  <= stallLiveIn;                    // RQ1
			zeroWait_q   <= zeroWaitActive;                 // RQ3
			vzero_q      <= vzeroD;
			posReached_q <= posReachedD;
			velReached_q <= velReachedD;
		end
	end

	// Sticky flags
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			w1c_q <= 14'h0000;
		end else begin
			w1c_q <= w1cD;
		end
	end

	// Position capture; right wins if both sides fire together
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			captured_q <= '0;
		end else if (latchReq[1]) begin
			captured_q <= presentPosition;                  // RQ16
		end else if (latchReq[0]) begin
			captured_q <= presentPosition;
		end
	end

	// Writable configuration and mask, byte lanes honoured
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			cfg_q  <= rss_pkg::CFG_RST;
			mask_q <= rss_pkg::MASK_RST;
		end else begin
			if (wrConfig) begin
				cfg_q <= ((cfg_q & keepLanes[11:0]) | wrLanes[11:0]) & rss_pkg::CFG_BITS;
			end
			if (wrMask) begin
				mask_q <= (mask_q & keepLanes[13:0]) | wrLanes[13:0];
			end
		end
	end

	// ==========================================================
	// Bus answer: ack one cycle after request, unmapped reads zero
	wire [31:0] readMux =
		hitStatus ? {18'h0, statusWord} :
		hitConfig ? {20'h00000, cfg_q} :
		hitMask   ? {18'h0, mask_q} :
		hitLatch  ? 32'(captured_q) : 32'h00000000;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
		end else begin
			ack_q <= busReq & ~ack_q;
			if (busReq & ~ack_q) begin
				dat_q <= readMux;
			end
		end
	end

	// Outputs; stall halt drops once its enable is withdrawn
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			irq_q       <= 1'b0;
			stallHalt_q <= 1'b0;
		end else begin
			irq_q       <= irqD;
			stallHalt_q <= w1cD[rss_pkg::ST_EV_STALL] & stallHalt; // RQ8
		end
	end

	assign wb_ack_o     = ack_q;
	assign wb_dat_o     = dat_q;
	assign irq          = irq_q;
	assign stallHaltOut = stallHalt_q;
	assign stopRightOut = swStop[1];
	assign stopLeftOut  = swStop[0];

	// ==========================================================
	// Checks
	stall_live_a: assert property (@(posedge clk) disable iff (!rstN) // RQ1
		rstN |=> statusWord[rss_pkg::ST_STALL_LIVE] == $past(stallLiveIn))
		else $error("stall live bit does not follow detector");
	second_move_a: assert property (@(posedge clk) disable iff (!rstN) // RQ2
		rstN && reverseEvent |=> statusWord[rss_pkg::ST_SECOND_MOVE])
		else $error("reverse flag not held");
	zero_wait_a: assert property (@(posedge clk) disable iff (!rstN) // RQ3
		rstN && zeroWaitActive |=> statusWord[rss_pkg::ST_ZERO_WAIT])
		else $error("zero wait bit missing");
	vzero_bit_a: assert property (@(posedge clk) disable iff (!rstN) // RQ4
		rstN |=> statusWord[rss_pkg::ST_VZERO] == ($past(presentVelocity) == '0))
		else $error("zero velocity bit wrong");
	pos_match_a: assert property (@(posedge clk) disable iff (!rstN) // RQ5
		(presentPosition != goalPosition) |=> !statusWord[rss_pkg::ST_POS_REACHED])
		else $error("position reached set while apart");
	vel_match_a: assert property (@(posedge clk) disable iff (!rstN) // RQ6
		rstN && (presentVelocity == topVelocity) |=> statusWord[rss_pkg::ST_VEL_REACHED])
		else $error("velocity reached missing");
	pos_event_a: assert property (@(posedge clk) disable iff (!rstN) // RQ7
		$rose(posReached_q) |-> w1c_q[rss_pkg::ST_EV_POS])
		else $error("position event not set on rise");
	w1c_zero_a: assert property (@(posedge clk) disable iff (!rstN) // RQ17
		(w1c_q[rss_pkg::ST_EV_POS] && !(wrStatus && wrLanes[rss_pkg::ST_EV_POS]))
		|=> w1c_q[rss_pkg::ST_EV_POS])
		else $error("sticky bit lost without write one");
	irq_or_a: assert property (@(posedge clk) disable iff (!rstN) // RQ12
		rstN |=> irq == $past(|(statusWord & mask_q & rss_pkg::IRQ_BITS)))
		else $error("interrupt does not match enabled events");
	latch_set_a: assert property (@(posedge clk) disable iff (!rstN) // RQ13
		latchReq[1] |=> w1c_q[rss_pkg::ST_LATCH_R] && captured_q == $past(presentPosition))
		else $error("right latch not captured");
	second_hold_a: assert property (@(posedge clk) disable iff (!rstN) // RQ2
		(w1c_q[rss_pkg::ST_SECOND_MOVE] && !(wrStatus && wrLanes[rss_pkg::ST_SECOND_MOVE]))
		|=> w1c_q[rss_pkg::ST_SECOND_MOVE])
		else $error("reverse flag lost without write one");
	stall_halt_a: assert property (@(posedge clk) disable iff (!rstN) // RQ8
		(stallLive_q && stallHalt) |=> w1c_q[rss_pkg::ST_EV_STALL] && stallHaltOut)
		else $error("stall stop event or halt missing");
	stop_irq_a: assert property (@(posedge clk) disable iff (!rstN) // RQ12
		(swStop[1] && mask_q[rss_pkg::ST_STOP_R]) |=> irq)
		else $error("right stop did not raise interrupt");
endmodule

// File: rss_pkg.sv
// Shared constants for the ramp and switch status block
package rss_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_CONFIG = 8'h04;
	localparam logic [7:0] OFS_MASK   = 8'h08;
	localparam logic [7:0] OFS_LATCH  = 8'h0c;

	// ==========================================================
	// Status word layout
	localparam int STAT_W         = 14;
	localparam int ST_STALL_LIVE  = 13;
	localparam int ST_SECOND_MOVE = 12;
	localparam int ST_ZERO_WAIT   = 11;
	localparam int ST_VZERO       = 10;
	localparam int ST_POS_REACHED = 9;
	localparam int ST_VEL_REACHED = 8;
	localparam int ST_EV_POS      = 7;
	localparam int ST_EV_STALL    = 6;
	localparam int ST_STOP_R      = 5;
	localparam int ST_STOP_L      = 4;
	localparam int ST_LATCH_R     = 3;
	localparam int ST_LATCH_L     = 2;
	localparam int ST_SW_R        = 1;
	localparam int ST_SW_L        = 0;
	localparam logic [13:0] W1C_BITS  = 14'h10cc;
	localparam logic [13:0] IRQ_BITS  = 14'h00f0;
	localparam logic [13:0] MASK_RST  = 14'h00f0;

	// ==========================================================
	// Switch configuration layout
	localparam int CFG_W           = 12;
	localparam int CF_STOP_L_EN    = 0;
	localparam int CF_POL_L        = 2;
	localparam int CF_LATCH_L_ACT  = 5;
	localparam int CF_LATCH_L_INA  = 6;
	localparam int CF_STALL_HALT   = 10;
	localparam int CF_SOFT_STOP    = 11;
	localparam logic [11:0] CFG_BITS = 12'hdef;
	localparam logic [11:0] CFG_RST  = 12'h000;
endpackage

// File: rss_sync2.sv
// Two-stage synchroniser for asynchronous pin levels
module rss_sync2 #(
	parameter int W = 2
) (
	input  wire logic         clk,
	input  wire logic         rstN,
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);
	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			meta_q  <= '0;
			syncOut <= '0;
		end else begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end
endmodule

// File: rss_switch_side.sv
// One reference switch: polarity, stop condition and latch edges
module rss_switch_side (
	input  wire logic clk,
	input  wire logic rstN,
	input  wire logic pinLevel,
	input  wire logic polarity,
	input  wire logic stopEnable,
	input  wire logic latchOnActive,
	input  wire logic latchOnInactive,
	input  wire logic movingToward,
	input  wire logic vzero,
	input  wire logic softStop,
	input  wire logic rampHold,
	input  wire logic oppositeCmd,
	output logic      activeQ,
	output logic      stopFlagQ,
	output logic      latchReqQ
);
	// ==========================================================
	// Level and edge decode
	wire activeD   = pinLevel ^ polarity;                 // RQ15
	wire goActive  = activeD & ~activeQ;
	wire goIdle    = ~activeD & activeQ;
	wire latchHit  = (goActive & latchOnActive) | (goIdle & latchOnInactive); // RQ16
	// Soft stop keeps the flag until motion toward the switch has ended
	wire mayRelease = ~softStop | vzero;                  // RQ10
	wire setStop   = stopEnable & activeD & movingToward & ~rampHold & ~oppositeCmd; // RQ9
	wire clrStop   = rampHold | oppositeCmd | (~activeD & mayRelease); // RQ9
	wire stopD     = stopEnable & (setStop | (stopFlagQ & ~clrStop));  // RQ11

	// Flags; hold and an opposite move keep a fresh set from landing
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			activeQ   <= 1'b0;
			stopFlagQ <= 1'b0;
			latchReqQ <= 1'b0;
		end else begin
			activeQ   <= activeD;
			stopFlagQ <= stopD;
			latchReqQ <= latchHit;
		end
	end

	disable_clears_a: assert property (@(posedge clk) disable iff (!rstN) !stopEnable |=> !stopFlagQ) // RQ11
		else $error("stop flag stayed set while disabled");
	polarity_level_a: assert property (@(posedge clk) disable iff (!rstN)
		rstN |=> activeQ == ($past(pinLevel) ^ $past(polarity))) // RQ15
		else $error("switch active level wrong");
endmodule

// File: rss_top_tb.sv
// Self-checking testbench for the ramp and switch status register
module rss_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Stimulus and observed signals
	logic               clk, resetN, wbCyc, wbStb, wbWe, wbAck;
	logic               stall, rev, zw, hold, mv, mvNeg, pinR, pinL;
	logic               irq, haltOut, stopR, stopL;
	logic        [7:0]  wbAdr;
	logic        [3:0]  wbSel;
	logic        [31:0] wbDat, wbQ, topV, pos, goal, q, r;
	logic signed [31:0] vel;
	int                 num_errors, cmp_count, cycles;

	rss_top u_rss_top (.clk(clk), .reset_n(resetN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_ack_o(wbAck),
		.wb_dat_o(wbQ), .presentVelocity(vel), .topVelocity(topV), .presentPosition(pos),
		.goalPosition(goal), .stallLiveIn(stall), .reverseEvent(rev), .zeroWaitActive(zw),
		.rampHold(hold), .moveCmd(mv), .moveCmdNegative(mvNeg), .rightHomeInput(pinR),
		.leftHomeInput(pinL), .irq(irq), .stallHaltOut(haltOut), .stopRightOut(stopR),
		.stopLeftOut(stopL));

	// ==========================================================
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Ceiling well above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			stop_test();
		end
	end

	// ==========================================================
	// Shared helpers
	task automatic stop_test();
		if (num_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
			num_errors++;
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One classic cycle; the master never assumes the ack latency
	task automatic wbx(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe  <= we;
		wbAdr <= a;
		wbDat <= d;
		wbSel <= 4'hf;
		do begin
			@(posedge clk);
			n++;
		end while (wbAck !== 1'b1 && n < 20);
		chk("wb ack", wbAck, 1'b1);
		q = wbQ;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask

	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		wbx(1'b0, a, 32'h0);
		chk(nm, q & m, e);
	endtask

	// Live status bits worked out from the motion inputs
	function automatic logic [31:0] liveExp();
		liveExp = 32'h0;
		liveExp[13] = stall;
		liveExp[11] = zw;
		liveExp[10] = (vel == 32'sh0);
		liveExp[9] = (pos == goal);
		liveExp[8] = (vel == topV);
	endfunction

	// ==========================================================
	// Main sequence
	initial begin
		{wbCyc, wbStb, wbWe, stall, rev, zw, hold, mv, mvNeg, pinR, pinL} = '0;
		{resetN, wbAdr, wbSel, wbDat, vel, pos, cycles, num_errors, cmp_count} = '0;
		topV = 32'h5;
		goal = 32'h1;
		void'($urandom(62));
		repeat (10) @(posedge clk);
		resetN <= 1'b1;
		tick(4);
		// Reset values, unmapped space and config readback
		rc("status", 8'h00, 32'hffffffff, 32'h400);
		rc("config", 8'h04, 32'hffffffff, 32'h0);
		rc("mask", 8'h08, 32'hffffffff, 32'hf0);
		rc("captured", 8'h0c, 32'hffffffff, 32'h0);
		chk("irq", irq, 1'b0);
		wbx(1'b1, 8'h10, 32'hffffffff);
		rc("unmapped", 8'h10, 32'hffffffff, 32'h0);
		wbx(1'b1, 8'h04, 32'hfff);
		rc("config", 8'h04, 32'hffffffff, 32'hdef);
		wbx(1'b1, 8'h04, 32'h0);
		wbx(1'b1, 8'h00, 32'h3fff);
		rc("sticky clear", 8'h00, 32'h10fc, 32'h0);
		// Random live levels, sticky bits masked out
		repeat (24) begin
			@(posedge clk);
			vel <= $signed($urandom_range(2)) - 1;
			topV <= $urandom_range(1);
			pos <= $urandom_range(1);
			goal <= $urandom_range(1);
			stall <= $urandom_range(1);
			zw <= $urandom_range(1);
			tick(1);
			rc("live", 8'h00, 32'h2f00, liveExp());
		end
		@(posedge clk);
		{stall, zw, vel, pos} <= '0;
		topV <= 32'h5;
		goal <= 32'h1;
		tick(2);
		wbx(1'b1, 8'h00, 32'h80);
		rc("pos event", 8'h00, 32'h80, 32'h0);
		@(posedge clk);
		pos <= 32'h1;
		tick(3);
		rc("pos event", 8'h00, 32'h80, 32'h80);
		chk("irq", irq, 1'b1);
		// Zeros on clearable bits 12 and 7, ones on read-only bits
		wbx(1'b1, 8'h00, 32'h2f7f);
		rc("status", 8'h00, 32'h2f80, 32'h680);
		wbx(1'b1, 8'h08, 32'h0);
		tick(3);
		chk("irq masked", irq, 1'b0);
		wbx(1'b1, 8'h08, 32'hf0);
		tick(3);
		chk("irq", irq, 1'b1);
		wbx(1'b1, 8'h00, 32'h80);
		tick(3);
		rc("pos event", 8'h00, 32'h80, 32'h0);
		chk("irq", irq, 1'b0);
		// Ramp reversal flag
		@(posedge clk);
		rev <= 1'b1;
		@(posedge clk);
		rev <= 1'b0;
		rc("reverse", 8'h00, 32'h1000, 32'h1000);
		wbx(1'b1, 8'h00, 32'h1000);
		rc("reverse", 8'h00, 32'h1000, 32'h0);
		// Stall stop event with halt enabled
		wbx(1'b1, 8'h04, 32'h400);
		@(posedge clk);
		stall <= 1'b1;
		tick(3);
		@(posedge clk);
		stall <= 1'b0;
		rc("stall event", 8'h00, 32'h40, 32'h40);
		chk("halt", haltOut, 1'b1);
		chk("irq", irq, 1'b1);
		wbx(1'b1, 8'h00, 32'h40);
		tick(2);
		rc("stall event", 8'h00, 32'h40, 32'h0);
		chk("halt", haltOut, 1'b0);
		chk("irq", irq, 1'b0);
		// Every polarity setting against random pin levels
		for (int p = 0; p < 4; p++) begin
			wbx(1'b1, 8'h04, 32'(p) << 2);
			repeat (3) begin
				@(posedge clk);
				pinR <= $urandom_range(1);
				pinL <= $urandom_range(1);
				tick(4);
				rc("switch level", 8'h00, 32'h3, {pinR ^ p[1], pinL ^ p[0]});
			end
		end
		@(posedge clk);
		{pinR, pinL} <= 2'b00;
		wbx(1'b1, 8'h04, 32'h80);
		// Position capture on enabled edges only
		r = $urandom;
		@(posedge clk);
		pos <= r;
		pinR <= 1'b1;
		tick(6);
		rc("captured", 8'h0c, 32'hffffffff, r);
		rc("latch flag", 8'h00, 32'hc, 32'h8);
		wbx(1'b1, 8'h00, 32'h8);
		rc("latch flag", 8'h00, 32'hc, 32'h0);
		wbx(1'b1, 8'h04, 32'h40);
		@(posedge clk);
		pinR <= 1'b0;
		pinL <= 1'b1;
		pos <= r + 1;
		tick(6);
		rc("captured", 8'h0c, 32'hffffffff, r);
		@(posedge clk);
		pinL <= 1'b0;
		tick(6);
		rc("captured", 8'h0c, 32'hffffffff, r + 1);
		rc("latch flag", 8'h00, 32'hc, 32'h4);
		wbx(1'b1, 8'h00, 32'hc);
		// Right stop: hold, same and opposite moves, disable
		wbx(1'b1, 8'h04, 32'h2);
		@(posedge clk);
		vel <= 32'sd3;
		pinR <= 1'b1;
		pos <= 32'h0;
		tick(6);
		chk("stop right", stopR, 1'b1);
		rc("stop flag", 8'h00, 32'h30, 32'h20);
		chk("irq", irq, 1'b1);
		@(posedge clk);
		hold <= 1'b1;
		tick(4);
		chk("stop right", stopR, 1'b0);
		chk("irq", irq, 1'b0);
		@(posedge clk);
		hold <= 1'b0;
		tick(4);
		chk("stop right", stopR, 1'b1);
		for (int d = 0; d < 2; d++) begin
			@(posedge clk);
			vel <= 32'sd0;
			mv <= 1'b1;
			mvNeg <= d[0];
			@(posedge clk);
			mv <= 1'b0;
			tick(3);
			chk("stop right", stopR, !d[0]);
		end
		@(posedge clk);
		vel <= 32'sd3;
		tick(4);
		chk("stop right", stopR, 1'b1);
		wbx(1'b1, 8'h04, 32'h0);
		tick(3);
		chk("stop right", stopR, 1'b0);
		// Soft stop left holds until motion has ended
		wbx(1'b1, 8'h04, 32'h801);
		@(posedge clk);
		vel <= -32'sd3;
		pinR <= 1'b0;
		pinL <= 1'b1;
		tick(6);
		rc("stop flag", 8'h00, 32'h30, 32'h10);
		@(posedge clk);
		pinL <= 1'b0;
		tick(6);
		chk("stop left", stopL, 1'b1);
		@(posedge clk);
		vel <= 32'sd0;
		tick(4);
		chk("stop left", stopL, 1'b0);
		stop_test();
	end
endmodule
